// [hw/fp_mem_to_reg.sv]
`timescale 1ns/1ps
module fp_mem_to_reg (
   input wire logic [79:0] mem_i,
   input wire fp_reg_pkg::mem_fmt_e fmt_i,
   output logic [81:0] reg_o
);
   import fp_reg_pkg::*;
   // ======================================
   // field extraction
   logic s_sg, s_db, s_de;
   logic [SG_EW-1:0] e_sg;
   logic [DB_EW-1:0] e_db;
   logic [DE_EW-1:0] e_de;
   assign s_sg = mem_i[SG_W-1];
   assign e_sg = mem_i[SG_W-2 -: SG_EW];
   assign s_db = mem_i[DB_W-1];
   assign e_db = mem_i[DB_W-2 -: DB_EW];
   assign s_de = mem_i[DE_W-1];
   assign e_de = mem_i[DE_W-2 -: DE_EW];
   fsig_t g_sg, g_db, g_de;
   assign g_sg = {(e_sg != '0), mem_i[SG_FW-1:0], 40'h0};
   assign g_db = {(e_db != '0), mem_i[DB_FW-1:0], 11'h0};
   assign g_de = mem_i[DE_FW-1:0];
   // rebias; zero exponent maps onto the format's denormal exponent, or onto exponent zero when the fraction is zero
   function automatic fexp_t rebias(input fexp_t e, input fexp_t b, input fexp_t emax,
                                    input logic zero_sig);
      fexp_t r;
      r = EXP_BIAS - b + e;
      if (e == EXP_ZERO) r = zero_sig ? EXP_ZERO : (EXP_BIAS - b + 17'h00001);
      if (e == emax) r = EXP_ONES;
      return r;
   endfunction : rebias
   fexp_t x_sg, x_db, x_de;
   assign x_sg = rebias({9'h0, e_sg}, SG_BIAS, 17'h000ff, mem_i[SG_FW-1:0] == '0);
   assign x_db = rebias({6'h0, e_db}, DB_BIAS, 17'h007ff, mem_i[DB_FW-1:0] == '0);
   // de denormals keep exponent zero, as the register format reads them directly
   assign x_de = (e_de == '0) ? EXP_ZERO : rebias({2'h0, e_de}, DE_BIAS, 17'h07fff, 1'b0);
   assign reg_o = (fmt_i == MEM_SG) ? {s_sg, x_sg, g_sg} :
                  (fmt_i == MEM_DB) ? {s_db, x_db, g_db} : {s_de, x_de, g_de};
endmodule : fp_mem_to_reg

// [hw/fp_reg_pkg.sv]
package fp_reg_pkg;
   // ======================================
   // register format
   localparam int REG_W = 82;
   localparam int EXP_W = 17;
   localparam int SIG_W = 64;
   localparam int SIGN_BIT = 81;
   localparam int INT_BIT = 63;
   localparam int QUIET_BIT = 62;
   typedef logic [REG_W-1:0] freg_t;
   typedef logic [EXP_W-1:0] fexp_t;
   typedef logic [SIG_W-1:0] fsig_t;
   localparam fexp_t EXP_ZERO = 17'h00000;
   localparam fexp_t EXP_ONES = 17'h1ffff;
   localparam fexp_t EXP_BIAS = 17'h0ffff;
   localparam fexp_t EXP_MIN = 17'h00001;
   localparam fexp_t EXP_MAXF = 17'h1fffe;
   localparam fexp_t EXP_PZMAX = 17'h1fffd;
   localparam fexp_t EXP_INT = 17'h1003e;
   localparam fexp_t EXP_DE_LO = 17'h0c001;
   localparam fexp_t EXP_DE_HI = 17'h13ffe;
   localparam fexp_t EXP_SG_LO = 17'h0ff81;
   localparam fexp_t EXP_SG_HI = 17'h1007e;
   localparam fexp_t EXP_DB_LO = 17'h0fc01;
   localparam fexp_t EXP_DB_HI = 17'h103fe;
   localparam int DENORM_POW = -16382;
   localparam fsig_t SIG_INT_ONLY = 64'h8000000000000000;
   localparam fsig_t SG_LOW_MASK = 64'h000000ffffffffff;
   localparam fsig_t DB_LOW_MASK = 64'h00000000000007ff;
   // ======================================
   // memory formats
   localparam int SG_W = 32;
   localparam int DB_W = 64;
   localparam int DE_W = 80;
   localparam int SG_EW = 8;
   localparam int SG_FW = 23;
   localparam int DB_EW = 11;
   localparam int DB_FW = 52;
   localparam int DE_EW = 15;
   localparam int DE_FW = 64;
   localparam fexp_t SG_BIAS = 17'h0007f;
   localparam fexp_t DB_BIAS = 17'h003ff;
   localparam fexp_t DE_BIAS = 17'h03fff;
   // ======================================
   // constant registers
   localparam freg_t FREG0_VAL = 82'h0;
   localparam freg_t FREG1_VAL = {1'b0, 17'h0ffff, 64'h8000000000000000};
   // ======================================
   // memory format select
   typedef enum logic [1:0] {
      MEM_SG = 2'h0,
      MEM_DB = 2'h1,
      MEM_DE = 2'h3
   } mem_fmt_e;
endpackage : fp_reg_pkg

// [hw/fp_register_format_classifier.sv]
`timescale 1ns/1ps
module fp_register_format_classifier (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [81:0] VALUE_I,
   input wire logic [6:0] FLOAT_REGISTER_IDX_I,
   input wire logic [79:0] MEM_I,
   input wire fp_reg_pkg::mem_fmt_e MEM_FMT_I,
   input wire logic [81:0] RESULT_I,
   output logic [81:0] CONST_VALUE_O,
   output logic CONST_HIT_O,
   output logic [81:0] MEM_REG_O,
   output logic [81:0] RESULT_O,
   output logic NEG_O,
   output logic [16:0] EXP_O,
   output logic [63:0] SIG_O,
   output logic [17:0] TRUE_EXP_O,
   output logic IS_NAN_O,
   output logic IS_QNAN_O,
   output logic IS_SNAN_O,
   output logic IS_INF_O,
   output logic IS_PSEUDO_NAN_O,
   output logic IS_PSEUDO_INF_O,
   output logic IS_ZERO_O,
   output logic IS_DENORM_O,
   output logic IS_PSEUDO_DENORM_O,
   output logic IS_NORMAL_O,
   output logic IS_UNNORMAL_O,
   output logic IS_PSEUDO_ZERO_O,
   output logic IS_NATVAL_O,
   output logic IS_CANON_INT_O,
   output logic IS_LARGE_INT_O,
   output logic IS_INT_INDEF_O,
   output logic IS_QNAN_INDEF_O,
   output logic IN_DE_RANGE_O,
   output logic IS_DE_PSEUDO_EQ_O,
   output logic IS_SG_NORMAL_O,
   output logic IS_SG_DENORM_O,
   output logic IS_DB_NORMAL_O,
   output logic IS_DB_DENORM_O,
   output logic [31:0] PAIR_HI_O,
   output logic [31:0] PAIR_LO_O
);
   import fp_reg_pkg::*;
   // ======================================
   // field split
   logic sgn;
   fexp_t ex;
   fsig_t sg;
   logic ib, qb, frac_nz, sig_nz;
   assign sgn = VALUE_I[SIGN_BIT];
   assign ex = VALUE_I[SIGN_BIT-1 -: EXP_W];
   assign sg = VALUE_I[SIG_W-1:0];
   assign ib = sg[INT_BIT];
   assign qb = sg[QUIET_BIT];
   assign frac_nz = (sg[INT_BIT-1:0] != '0);
   assign sig_nz = (sg != '0);

   function automatic logic in_rng(input fexp_t e, input fexp_t lo, input fexp_t hi);
      return (e >= lo) && (e <= hi);
   endfunction : in_rng

   // ======================================
   // exponent decode
   logic ex_ones, ex_zero, ex_fin;
   assign ex_ones = (ex == EXP_ONES);
   assign ex_zero = (ex == EXP_ZERO);
   assign ex_fin = in_rng(ex, EXP_MIN, EXP_MAXF);
   // true power of two; zero exponent uses the denormal power
   logic [17:0] true_exp;
   assign true_exp = ex_zero ? 18'(DENORM_POW) : ({1'b0, ex} - {1'b0, EXP_BIAS});

   // ======================================
   // classes
   logic c_inf, c_qnan, c_snan, c_pnan, c_pinf;
   assign c_inf = ex_ones & ib & ~frac_nz;
   assign c_qnan = ex_ones & ib & qb;
   assign c_snan = ex_ones & ib & ~qb & frac_nz;
   assign c_pnan = ex_ones & ~ib & frac_nz;
   assign c_pinf = ex_ones & ~sig_nz;
   logic c_zero, c_den, c_pden;
   assign c_zero = ex_zero & ~sig_nz;
   assign c_den = ex_zero & sig_nz & ~ib;
   assign c_pden = ex_zero & ib;
   logic c_norm, c_pz, c_natval, c_unn;
   assign c_norm = ex_fin & ib;
   // pseudo-zeros count as unnormals, never as zeros
   assign c_pz = ~sig_nz & (in_rng(ex, EXP_MIN, EXP_PZMAX) | ((ex == EXP_MAXF) & sgn));
   assign c_natval = ~sig_nz & (ex == EXP_MAXF) & ~sgn;
   assign c_unn = (ex_fin & ~ib & sig_nz) | c_pz | c_pden;
   logic c_cint, c_lint, c_iind;
   assign c_cint = (ex == EXP_INT) & ~sgn;
   assign c_lint = c_cint & ib;
   assign c_iind = c_cint & (sg == SIG_INT_ONLY);
   logic c_de_rng, c_de_eq;
   assign c_de_rng = ib & in_rng(ex, EXP_DE_LO, EXP_DE_HI);
   assign c_de_eq = ib & (ex == EXP_DE_LO);
   logic sg_low0, db_low0;
   assign sg_low0 = ((sg & SG_LOW_MASK) == '0);
   assign db_low0 = ((sg & DB_LOW_MASK) == '0);
   logic c_sgn, c_sgd, c_dbn, c_dbd;
   assign c_sgn = sg_low0 & ib & in_rng(ex, EXP_SG_LO, EXP_SG_HI);
   assign c_sgd = sg_low0 & ~ib & sig_nz & (ex == EXP_SG_LO);
   assign c_dbn = db_low0 & ib & in_rng(ex, EXP_DB_LO, EXP_DB_HI);
   assign c_dbd = db_low0 & ~ib & sig_nz & (ex == EXP_DB_LO);

   // ======================================
   // constant registers
   logic hit0, hit1;
   assign hit0 = (FLOAT_REGISTER_IDX_I == 7'h00);
   assign hit1 = (FLOAT_REGISTER_IDX_I == 7'h01);
   // one fixed value for every consumer, paired or integer alike
   freg_t cval;
   assign cval = hit1 ? FREG1_VAL : FREG0_VAL;

   // ======================================
   // result canonicalisation
   // pseudo encodings are accepted as operands but never written back
   logic r_s, r_ib, r_fnz;
   fexp_t r_e;
   fsig_t r_g;
   assign r_s = RESULT_I[SIGN_BIT];
   assign r_e = RESULT_I[SIGN_BIT-1 -: EXP_W];
   assign r_g = RESULT_I[SIG_W-1:0];
   assign r_ib = r_g[INT_BIT];
   assign r_fnz = (r_g[INT_BIT-1:0] != '0);
   logic r_pnan, r_pinf, r_pz, r_pden, r_de_den;
   assign r_pnan = (r_e == EXP_ONES) & ~r_ib & r_fnz;
   assign r_pinf = (r_e == EXP_ONES) & (r_g == '0);
   assign r_pz = (r_g == '0) & (in_rng(r_e, EXP_MIN, EXP_PZMAX) | ((r_e == EXP_MAXF) & r_s));
   assign r_pden = (r_e == EXP_ZERO) & r_ib;
   assign r_de_den = (r_e == EXP_DE_LO) & ~r_ib & r_fnz;
   freg_t res_fix;
   assign res_fix = r_pnan ? {r_s, EXP_ONES, r_g | SIG_INT_ONLY | (SIG_INT_ONLY >> 1)} :
                    r_pinf ? {r_s, EXP_ONES, SIG_INT_ONLY} :
                    r_pz ? {r_s, EXP_ZERO, 64'h0} :
                    r_pden ? {r_s, EXP_DE_LO, r_g} :
                    r_de_den ? {r_s, EXP_ZERO, r_g} :
                    RESULT_I;

   // ======================================
   // memory conversion
   freg_t mem_reg;
   fp_mem_to_reg u_mem (
      .mem_i(MEM_I),
      .fmt_i(MEM_FMT_I),
      .reg_o(mem_reg)
   );

   // ======================================
   // registered outputs
   // one pipeline stage keeps data outputs on flip-flops; adds a cycle of latency
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         CONST_VALUE_O <= '0;
         CONST_HIT_O <= 1'b0;
         MEM_REG_O <= '0;
         RESULT_O <= '0;
         NEG_O <= 1'b0;
         EXP_O <= '0;
         SIG_O <= '0;
         TRUE_EXP_O <= '0;
         PAIR_HI_O <= '0;
         PAIR_LO_O <= '0;
      end else begin
         CONST_VALUE_O <= cval;
         CONST_HIT_O <= hit0 | hit1;
         MEM_REG_O <= mem_reg;
         RESULT_O <= res_fix;
         NEG_O <= sgn;
         EXP_O <= ex;
         SIG_O <= sg;
         TRUE_EXP_O <= true_exp;
         PAIR_HI_O <= sg[SIG_W-1 -: SG_W];
         PAIR_LO_O <= sg[SG_W-1:0];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         IS_NAN_O <= 1'b0;
         IS_QNAN_O <= 1'b0;
         IS_SNAN_O <= 1'b0;
         IS_INF_O <= 1'b0;
         IS_PSEUDO_NAN_O <= 1'b0;
         IS_PSEUDO_INF_O <= 1'b0;
         IS_ZERO_O <= 1'b0;
         IS_DENORM_O <= 1'b0;
         IS_PSEUDO_DENORM_O <= 1'b0;
         IS_NORMAL_O <= 1'b0;
         IS_UNNORMAL_O <= 1'b0;
         IS_PSEUDO_ZERO_O <= 1'b0;
         IS_NATVAL_O <= 1'b0;
      end else begin
         IS_NAN_O <= c_qnan | c_snan;
         IS_QNAN_O <= c_qnan;
         IS_SNAN_O <= c_snan;
         IS_INF_O <= c_inf;
         IS_PSEUDO_NAN_O <= c_pnan;
         IS_PSEUDO_INF_O <= c_pinf;
         IS_ZERO_O <= c_zero;
         IS_DENORM_O <= c_den;
         IS_PSEUDO_DENORM_O <= c_pden;
         IS_NORMAL_O <= c_norm;
         IS_UNNORMAL_O <= c_unn;
         IS_PSEUDO_ZERO_O <= c_pz;
         IS_NATVAL_O <= c_natval;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         IS_CANON_INT_O <= 1'b0;
         IS_LARGE_INT_O <= 1'b0;
         IS_INT_INDEF_O <= 1'b0;
         IS_QNAN_INDEF_O <= 1'b0;
         IN_DE_RANGE_O <= 1'b0;
         IS_DE_PSEUDO_EQ_O <= 1'b0;
         IS_SG_NORMAL_O <= 1'b0;
         IS_SG_DENORM_O <= 1'b0;
         IS_DB_NORMAL_O <= 1'b0;
         IS_DB_DENORM_O <= 1'b0;
      end else begin
         IS_CANON_INT_O <= c_cint;
         IS_LARGE_INT_O <= c_lint;
         IS_INT_INDEF_O <= c_iind;
         IS_QNAN_INDEF_O <= c_qnan & sgn & (sg == (SIG_INT_ONLY | (SIG_INT_ONLY >> 1)));
         IN_DE_RANGE_O <= c_de_rng;
         IS_DE_PSEUDO_EQ_O <= c_de_eq;
         IS_SG_NORMAL_O <= c_sgn;
         IS_SG_DENORM_O <= c_sgd;
         IS_DB_NORMAL_O <= c_dbn;
         IS_DB_DENORM_O <= c_dbd;
      end
   end
   // rounding method and fused/min/max arithmetic live in the execution units
   // that consume these flags; this stage only classifies operands, supplies the constant registers, converts memory formats and canonicalises results.
endmodule : fp_register_format_classifier

// [tb/fp_classifier_props.sv]
`timescale 1ns/1ps
module fp_classifier_props (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [81:0] VALUE_I,
   input wire logic [6:0] FLOAT_REGISTER_IDX_I,
   input wire logic [81:0] RESULT_I,
   input wire logic [81:0] CONST_VALUE_O,
   input wire logic CONST_HIT_O,
   input wire logic [81:0] RESULT_O,
   input wire logic NEG_O,
   input wire logic IS_ZERO_O,
   input wire logic IS_INF_O,
   input wire logic IS_QNAN_O,
   input wire logic IS_NORMAL_O,
   input wire logic IN_DE_RANGE_O
);
   // ======================================
   // qualifier: outputs only track inputs once a sampled edge has passed
   // two stages: $past must see a clean edge whichever side of the update it reads
   logic live_ff;
   logic live2_ff;
   always_ff @(posedge CLK_I) begin
      live_ff <= !RST_I;
      live2_ff <= live_ff && !RST_I;
   end
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I || !live_ff || !live2_ff);
   wire [16:0] v_exp = VALUE_I[80:64];
   // ======================================
   // sequences
   sequence s_idx_one;
      FLOAT_REGISTER_IDX_I == 7'h01;
   endsequence
   sequence s_res_de_unnorm;
      RESULT_I[80:64] == 17'h0c001 && !RESULT_I[63] && RESULT_I[62:0] != 63'h0;
   endsequence
   // ======================================
   // assertions
   AST_CONST_HIT: assert property (CONST_HIT_O == ($past(FLOAT_REGISTER_IDX_I) <= 7'h01))
      else $error("constant hit wrong");
   AST_CONST_ONE: assert property (s_idx_one |=>
      CONST_VALUE_O == {1'b0, 17'h0ffff, 64'h8000000000000000}) else $error("register one wrong");
   AST_SIGN: assert property (NEG_O == $past(VALUE_I[81]))
      else $error("sign wrong");
   AST_ZERO: assert property (IS_ZERO_O == ($past(VALUE_I[80:0]) == 81'h0))
      else $error("zero flag wrong");
   AST_INF: assert property (IS_INF_O ==
      ($past(VALUE_I[80:0]) == {17'h1ffff, 64'h8000000000000000})) else $error("inf flag wrong");
   AST_QNAN: assert property (v_exp == 17'h1ffff && VALUE_I[63:62] == 2'h3 |=> IS_QNAN_O)
      else $error("quiet nan missed");
   AST_NORMAL: assert property (VALUE_I[63] && v_exp != 17'h0 && v_exp != 17'h1ffff
      |=> IS_NORMAL_O) else $error("normal missed");
   AST_DE_RANGE: assert property (VALUE_I[63] && v_exp inside {[17'h0c001:17'h13ffe]}
      |=> IN_DE_RANGE_O) else $error("extended range missed");
   AST_RES_INT_BIT: assert property (RESULT_O[80:64] == 17'h1ffff |-> RESULT_O[63])
      else $error("pseudo result");
   AST_RES_DENORM: assert property (s_res_de_unnorm |=> RESULT_O[80:64] == 17'h0
      && RESULT_O[62:0] == $past(RESULT_I[62:0])) else $error("denormal result exponent");
endmodule : fp_classifier_props

// [tb/fp_exec_model.sv]
`timescale 1ns/1ps
module fp_exec_model (
   input wire logic go_i,
   input wire logic [81:0] val_i,
   output logic [81:0] result_o
);
   // ======================================
   // execution unit result bus, zero while idle
   assign result_o = go_i ? val_i : 82'h0;
endmodule : fp_exec_model

// [tb/tb_fp_register_format_classifier.sv]
`timescale 1ns/1ps
module tb_fp_register_format_classifier;
   import fp_reg_pkg::*;
   // ======================================
   // signals: named as the ports, so the instance binds them by name
   logic CLK_I, RST_I, go;
   logic [81:0] VALUE_I, RESULT_I, res_val, CONST_VALUE_O, MEM_REG_O, RESULT_O;
   logic [6:0] FLOAT_REGISTER_IDX_I;
   logic [79:0] MEM_I;
   mem_fmt_e MEM_FMT_I;
   logic CONST_HIT_O, NEG_O, IS_NAN_O, IS_QNAN_O, IS_SNAN_O, IS_INF_O, IS_PSEUDO_NAN_O;
   logic IS_PSEUDO_INF_O, IS_ZERO_O, IS_DENORM_O, IS_PSEUDO_DENORM_O, IS_NORMAL_O;
   logic IS_UNNORMAL_O, IS_PSEUDO_ZERO_O, IS_NATVAL_O, IS_CANON_INT_O, IS_LARGE_INT_O;
   logic IS_INT_INDEF_O, IS_QNAN_INDEF_O, IN_DE_RANGE_O, IS_DE_PSEUDO_EQ_O;
   logic IS_SG_NORMAL_O, IS_SG_DENORM_O, IS_DB_NORMAL_O, IS_DB_DENORM_O;
   logic [16:0] EXP_O;
   logic [63:0] SIG_O;
   logic [17:0] TRUE_EXP_O;
   logic [31:0] PAIR_HI_O, PAIR_LO_O;
   int errors = 0;
   int samples_checked = 0;
   wire [19:0] flags = {IS_NAN_O, IS_QNAN_O, IS_SNAN_O, IS_INF_O, IS_ZERO_O, IS_DENORM_O,
      IS_PSEUDO_DENORM_O, IS_NORMAL_O, IS_UNNORMAL_O, IS_PSEUDO_ZERO_O, IS_NATVAL_O,
      IS_CANON_INT_O, IS_LARGE_INT_O, IS_INT_INDEF_O, IN_DE_RANGE_O, IS_DE_PSEUDO_EQ_O,
      IS_SG_NORMAL_O, IS_SG_DENORM_O, IS_DB_NORMAL_O, IS_DB_DENORM_O};
   wire [22:0] odd_flags = {IS_PSEUDO_NAN_O, IS_PSEUDO_INF_O, IS_QNAN_INDEF_O, flags};
   fp_register_format_classifier i_dut (
      .CLK_I(CLK_I), .RST_I(RST_I), .VALUE_I(VALUE_I),
      .FLOAT_REGISTER_IDX_I(FLOAT_REGISTER_IDX_I), .MEM_I(MEM_I), .MEM_FMT_I(MEM_FMT_I),
      .RESULT_I(RESULT_I), .CONST_VALUE_O(CONST_VALUE_O), .CONST_HIT_O(CONST_HIT_O),
      .MEM_REG_O(MEM_REG_O), .RESULT_O(RESULT_O), .NEG_O(NEG_O), .EXP_O(EXP_O),
      .SIG_O(SIG_O), .TRUE_EXP_O(TRUE_EXP_O), .IS_NAN_O(IS_NAN_O), .IS_QNAN_O(IS_QNAN_O),
      .IS_SNAN_O(IS_SNAN_O), .IS_INF_O(IS_INF_O), .IS_PSEUDO_NAN_O(IS_PSEUDO_NAN_O),
      .IS_PSEUDO_INF_O(IS_PSEUDO_INF_O), .IS_ZERO_O(IS_ZERO_O), .IS_DENORM_O(IS_DENORM_O),
      .IS_PSEUDO_DENORM_O(IS_PSEUDO_DENORM_O), .IS_NORMAL_O(IS_NORMAL_O),
      .IS_UNNORMAL_O(IS_UNNORMAL_O), .IS_PSEUDO_ZERO_O(IS_PSEUDO_ZERO_O),
      .IS_NATVAL_O(IS_NATVAL_O), .IS_CANON_INT_O(IS_CANON_INT_O),
      .IS_LARGE_INT_O(IS_LARGE_INT_O), .IS_INT_INDEF_O(IS_INT_INDEF_O),
      .IS_QNAN_INDEF_O(IS_QNAN_INDEF_O), .IN_DE_RANGE_O(IN_DE_RANGE_O),
      .IS_DE_PSEUDO_EQ_O(IS_DE_PSEUDO_EQ_O), .IS_SG_NORMAL_O(IS_SG_NORMAL_O),
      .IS_SG_DENORM_O(IS_SG_DENORM_O), .IS_DB_NORMAL_O(IS_DB_NORMAL_O),
      .IS_DB_DENORM_O(IS_DB_DENORM_O), .PAIR_HI_O(PAIR_HI_O), .PAIR_LO_O(PAIR_LO_O)
   );
   fp_exec_model i_exec (.go_i(go), .val_i(res_val), .result_o(RESULT_I));
   // ======================================
   // tables: operand and expected flag vector, then memory conversion and result canonicalisation
   typedef struct {logic s; fexp_t e; fsig_t m; logic [19:0] f;} row_s;
   row_s rows[18] = '{'{1'b0, 17'h0, 64'h0, 20'h08000}, '{1'b1, 17'h0, 64'h0, 20'h08000},
      '{1'b0, EXP_ONES, SIG_INT_ONLY, 20'h10000}, '{1'b1, EXP_ONES, 64'hc000000000000000, 20'hc0000},
      '{1'b0, EXP_ONES, SIG_INT_ONLY | 64'h1, 20'ha0000}, '{1'b0, 17'h0, 64'h1, 20'h04000},
      '{1'b0, 17'h0, SIG_INT_ONLY, 20'h02800}, '{1'b0, 17'h0ffff, SIG_INT_ONLY, 20'h0102a},
      '{1'b0, 17'h0c001, SIG_INT_ONLY, 20'h01030}, '{1'b0, 17'h0ff81, 64'h4000000000000000, 20'h00804},
      '{1'b0, 17'h0fc01, 64'h800, 20'h00801}, '{1'b0, 17'h1003e, SIG_INT_ONLY, 20'h011ea},
      '{1'b0, 17'h1003e, 64'h5, 20'h00900}, '{1'b1, 17'h1fffd, 64'h0, 20'h00c00},
      '{1'b1, 17'h1fffe, 64'h0, 20'h00c00}, '{1'b0, 17'h1fffe, 64'h0, 20'h00200},
      '{1'b0, 17'h13ffe, SIG_INT_ONLY, 20'h01020}, '{1'b0, 17'h0ffff, SIG_INT_ONLY | 64'h1000, 20'h01022}};
   typedef struct {mem_fmt_e f; logic [79:0] mem; freg_t mexp; freg_t rin; freg_t rexp;} conv_s;
   conv_s conv[8] = '{'{MEM_SG, 80'h3f800000, FREG1_VAL, {1'b0, EXP_ONES, 64'h0}, {1'b0, EXP_ONES, SIG_INT_ONLY}},
      '{MEM_DB, 80'h3ff0000000000000, FREG1_VAL, {1'b0, EXP_ONES, 64'h1}, {1'b0, EXP_ONES, 64'hc000000000000001}},
      '{MEM_DE, 80'h3fff8000000000000000, FREG1_VAL, {1'b1, 17'h00005, 64'h0}, {1'b1, 81'h0}},
      '{MEM_SG, 80'h1, {1'b0, 17'h0ff81, 64'h10000000000}, {1'b0, 17'h0, SIG_INT_ONLY | 64'h1},
         {1'b0, EXP_DE_LO, SIG_INT_ONLY | 64'h1}},
      '{MEM_DB, 80'h1, {1'b0, 17'h0fc01, 64'h800}, {1'b0, EXP_DE_LO, 64'h4000000000000000},
         {1'b0, 17'h0, 64'h4000000000000000}},
      '{MEM_SG, 80'hbf800000, {1'b1, 17'h0ffff, SIG_INT_ONLY}, FREG1_VAL, FREG1_VAL},
      '{MEM_SG, 80'h7f800000, {1'b0, EXP_ONES, SIG_INT_ONLY}, 82'h0, 82'h0},
      '{MEM_DE, 80'h0, 82'h0, {1'b1, 17'h0ffff, SIG_INT_ONLY}, {1'b1, 17'h0ffff, SIG_INT_ONLY}}};
   // ======================================
   // helpers
   // wide enough for the grouped reset compares, which exceed one register value
   task check(input string name, input logic [127:0] seen, input logic [127:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   function automatic logic [17:0] texp(input logic [16:0] e);
      return (e == 17'h0) ? 18'h3c002 : {1'b0, e} - 18'h0ffff;
   endfunction : texp
   task end_of_test;
      if (errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   always #5 CLK_I = ~CLK_I;
   initial begin
      repeat (1000) @(posedge CLK_I);
      errors++;
      end_of_test();
   end
   // ======================================
   // main sequence: back to back, each output read one edge after its input
   initial begin
      CLK_I = 1'b0;
      RST_I = 1'b1;
      go = 1'b1;
      VALUE_I = FREG1_VAL;
      res_val = FREG1_VAL;
      FLOAT_REGISTER_IDX_I = 7'h01;
      MEM_I = 80'h3f800000;
      MEM_FMT_I = MEM_SG;
      repeat (4) @(negedge CLK_I);
      check("reset", {CONST_HIT_O, flags, RESULT_O}, 82'h0);
      RST_I = 1'b0;
      for (int i = 0; i <= 18; i++) begin
         @(negedge CLK_I);
         if (i > 0) begin
            check("flags", flags, rows[i-1].f);
            check("neg", NEG_O, rows[i-1].s);
            check("fields", {EXP_O, SIG_O}, {rows[i-1].e, rows[i-1].m});
            check("true_exp", TRUE_EXP_O, texp(rows[i-1].e));
            check("pair", {PAIR_HI_O, PAIR_LO_O}, rows[i-1].m);
         end
         if (i < 18) VALUE_I = {rows[i].s, rows[i].e, rows[i].m};
      end
      for (int i = 0; i <= 8; i++) begin
         @(negedge CLK_I);
         if (i > 0) begin
            check("mem_reg", MEM_REG_O, conv[i-1].mexp);
            check("result", RESULT_O, conv[i-1].rin === conv[i-1].rexp ? conv[i-1].rin
               : conv[i-1].rexp);
            check("const_hit", CONST_HIT_O, (i - 1) < 2);
            check("const", CONST_VALUE_O, (i - 1) == 1 ? FREG1_VAL : FREG0_VAL);
         end
         if (i < 8) begin
            MEM_FMT_I = conv[i].f;
            MEM_I = conv[i].mem;
            res_val = conv[i].rin;
            FLOAT_REGISTER_IDX_I = 7'(i);
         end
      end
      // unsupported encodings, the QNaN indefinite, and the result bus left idle
      go = 1'b0;
      VALUE_I = {1'b0, EXP_ONES, 64'h1};
      @(negedge CLK_I);
      check("pseudo_nan", odd_flags, 23'h400000);
      check("idle_result", RESULT_O, 82'h0);
      VALUE_I = {1'b1, EXP_ONES, 64'h0};
      @(negedge CLK_I);
      check("pseudo_inf", odd_flags, 23'h200000);
      VALUE_I = {1'b1, EXP_ONES, 64'hc000000000000000};
      @(negedge CLK_I);
      check("qnan_indef", odd_flags, 23'h1c0000);
      // a reset in mid-run must clear what the previous edge produced
      FLOAT_REGISTER_IDX_I = 7'h01;
      VALUE_I = FREG1_VAL;
      @(negedge CLK_I);
      RST_I = 1'b1;
      @(negedge CLK_I);
      check("mid_reset", {CONST_HIT_O, flags, RESULT_O}, 82'h0);
      check("mid_reset_const", {CONST_VALUE_O, EXP_O, NEG_O}, 100'h0);
      check("mid_reset_sig", {SIG_O, PAIR_HI_O, PAIR_LO_O}, 128'h0);
      check("mid_reset_data", {MEM_REG_O, TRUE_EXP_O, odd_flags[22:20], NEG_O}, 104'h0);
      RST_I = 1'b0;
      @(negedge CLK_I);
      check("after_reset", CONST_VALUE_O, FREG1_VAL);
      check("after_reset_fields", {CONST_HIT_O, EXP_O, SIG_O}, {1'b1, FREG1_VAL[80:0]});
      end_of_test();
   end
endmodule : tb_fp_register_format_classifier
bind fp_register_format_classifier fp_classifier_props i_props (
   .CLK_I(CLK_I), .RST_I(RST_I), .VALUE_I(VALUE_I),
   .FLOAT_REGISTER_IDX_I(FLOAT_REGISTER_IDX_I), .RESULT_I(RESULT_I),
   .CONST_VALUE_O(CONST_VALUE_O), .CONST_HIT_O(CONST_HIT_O), .RESULT_O(RESULT_O),
   .NEG_O(NEG_O), .IS_ZERO_O(IS_ZERO_O), .IS_INF_O(IS_INF_O), .IS_QNAN_O(IS_QNAN_O),
   .IS_NORMAL_O(IS_NORMAL_O), .IN_DE_RANGE_O(IN_DE_RANGE_O)
);
